// file: hdl/vtg_pkg.sv
// Overview of operation
// - active line length is twelve bits
// - link bit picks channel A or both
// - twelve-bit vertical size, pattern generator only
// - delay incoming syncs by programmed pixel count
// - programmed delay adds to ten-clock pipeline
// - hsync width is ten-bit pixel count
// - vsync width is ten-bit line count
// - back porch pixels follow hsync end
// - pattern mode vertical back porch lines
// - pattern mode horizontal front porch pixels
// - pattern mode vertical front porch lines
// - enable bit starts internal test pattern
// - pattern-only fields unused in normal mode
// - link bit resets single, channel A only
// - syncs active low unless polarity cleared
package vtg_pkg;
  // register offsets
  localparam logic [7:0] REG_LINK_CFG    = 8'h18;
  localparam logic [7:0] REG_CM_TRIM     = 8'h1b;
  localparam logic [7:0] REG_LINE_LEN_LO = 8'h20;
  localparam logic [7:0] REG_LINE_LEN_HI = 8'h21;
  localparam logic [7:0] REG_VSIZE_LO    = 8'h24;
  localparam logic [7:0] REG_VSIZE_HI    = 8'h25;
  localparam logic [7:0] REG_SDLY_LO     = 8'h28;
  localparam logic [7:0] REG_SDLY_HI     = 8'h29;
  localparam logic [7:0] REG_HSW_LO      = 8'h2c;
  localparam logic [7:0] REG_HSW_HI      = 8'h2d;
  localparam logic [7:0] REG_VSW_LO      = 8'h30;
  localparam logic [7:0] REG_VSW_HI      = 8'h31;
  localparam logic [7:0] REG_HBP         = 8'h34;
  localparam logic [7:0] REG_VBP         = 8'h36;
  localparam logic [7:0] REG_HFP         = 8'h38;
  localparam logic [7:0] REG_VFP         = 8'h3a;
  localparam logic [7:0] REG_PATTERN     = 8'h3c;
  localparam logic [7:0] REG_STATUS      = 8'h3e;
  localparam int         REG_SPACE       = 64;
  // field positions and masks
  localparam int         LINK_SINGLE_BIT = 4;
  localparam int         VS_LOW_BIT      = 5;
  localparam int         HS_LOW_BIT      = 6;
  localparam int         PATTERN_EN_BIT  = 4;
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] MASK_NIBBLE     = 8'h0f;
  localparam logic [7:0] MASK_TWO        = 8'h03;
  localparam logic [7:0] MASK_PATTERN    = 8'h10;
  localparam logic [7:0] MASK_NONE       = 8'h00;
  // reset values
  localparam logic [7:0] LINK_CFG_RESET  = 8'h70;
  localparam logic [7:0] REG_RESET       = 8'h00;
  // timing
  localparam logic [12:0] DLY_LATENCY    = 13'h00a;
  localparam logic [11:0] MIN_SYNC_DELAY = 12'h020;
  localparam int          COMP_W         = 8;
  localparam int          BAR_LSB        = 5;
  typedef logic [3*COMP_W-1:0] pixel_t;
  typedef struct packed {
    logic [11:0] line_len;  // active pixels per line
    logic [11:0] vsize;     // active lines, pattern only
    logic [11:0] sync_dly;  // re-time delay in pixel clocks
    logic [9:0]  hsw;       // hsync width, pixel clocks
    logic [9:0]  vsw;       // vsync width, lines
    logic [7:0]  hbp;       // horizontal back porch
    logic [7:0]  vbp;       // vertical back porch
    logic [7:0]  hfp;       // horizontal front porch
    logic [7:0]  vfp;       // vertical front porch
    logic        tp_en;     // pattern generator enable
    logic        single;    // single link, channel A only
    logic        hs_low;    // hsync active low
    logic        vs_low;    // vsync active low
  } cfg_t;
  typedef struct packed {
    logic   de;             // active pixel
    logic   hs;             // hsync at pin polarity
    logic   vs;             // vsync at pin polarity
    pixel_t rgb;            // pixel data
  } vid_t;
endpackage

// file: hdl/lvds_video_timing_generator.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// pixel fifo: flip-flop storage, count-based full and empty
module pix_fifo
  import vtg_pkg::*;
#(
  parameter int W = 24,
  parameter int D = 16
)(
  input  wire logic         clk,       // pixel clock
  input  wire logic         rst,       // synchronous reset
  input  wire logic         ce,        // clock enable
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // not full
  input  wire logic [W-1:0] in_data,   // write data
  output logic              out_valid, // not empty
  input  wire logic         out_ready, // read request
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];            // storage
  logic [AW-1:0] wp_q;                 // write index
  logic [AW-1:0] rp_q;                 // read index
  logic [AW:0]   cnt_q;                // fill level
  logic          push;                 // write this cycle
  logic          pop;                  // read this cycle
  assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // storage write
  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end
  // pointers and level; indices wrap because depth is a power of two
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop)  rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module lvds_video_timing_generator
  import vtg_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)(
  input  wire logic       clk,          // control clock, 250 MHz
  input  wire logic       rst,          // synchronous reset, active high
  input  wire logic       ce,           // clock enable, freezes all state but the clock-crossing synchronisers
  input  wire logic       csr_wr,       // register write strobe
  input  wire logic       csr_rd,       // register read strobe
  input  wire logic [7:0] csr_addr,     // register offset
  input  wire logic [7:0] csr_wdata,    // write data
  output logic [7:0]      csr_rdata,    // read data, one cycle after csr_rd
  input  wire logic       pix_clk,      // lvds pixel clock
  input  wire logic       in_valid,     // incoming pixel valid
  output logic            in_ready,     // pixel buffer has room
  input  wire pixel_t     in_pixel,     // incoming pixel
  input  wire logic       in_hs_evt,    // received hsync event pulse
  input  wire logic       in_vs_evt,    // received vsync event pulse
  output vid_t            vid_out,      // re-timed video to serializer
  output logic            chan_a_en,    // channel A output enable
  output logic            chan_b_en,    // channel B output enable
  output logic [7:0]      cm_trim       // analog common-mode trim bits
);
  typedef enum {H_IDLE, H_SYNC, H_BP, H_ACT, H_FP} hstate_t;
  typedef enum {V_SYNC, V_BP, V_ACT, V_FP} vstate_t;
  // pixel side starts from the link defaults, not from zeros, so sync polarity
  // and channel B are already right before the first hand-off arrives
  localparam cfg_t CFG_RESET = '{single: LINK_CFG_RESET[LINK_SINGLE_BIT],
                                 hs_low: LINK_CFG_RESET[HS_LOW_BIT],
                                 vs_low: LINK_CFG_RESET[VS_LOW_BIT], default: '0};

  ////////////////////////////////////////////////////////////////////////////
  // control domain: registers and config hand-off
  logic [7:0] reg_q [REG_SPACE];        // register storage
  cfg_t       cfg_now;                  // config as programmed
  cfg_t       snap_q;                   // config held during hand-off
  logic       dirty_q;                  // config changed since last send
  logic       req_q;                    // hand-off request toggle
  logic       ack_s1_q, ack_s2_q;       // ack synchroniser
  logic       stat_s1_q, stat_s2_q;     // pattern-running synchroniser
  logic       hit;                      // address inside register space
  logic [5:0] idx;                      // register index

  // writable bits of each offset; zero marks unmapped
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      REG_LINK_CFG, REG_CM_TRIM, REG_LINE_LEN_LO, REG_VSIZE_LO, REG_SDLY_LO,
      REG_HSW_LO, REG_VSW_LO, REG_HBP, REG_VBP, REG_HFP, REG_VFP: wmask = MASK_FULL;
      REG_LINE_LEN_HI, REG_VSIZE_HI, REG_SDLY_HI:                  wmask = MASK_NIBBLE;
      REG_HSW_HI, REG_VSW_HI:                                      wmask = MASK_TWO;
      REG_PATTERN:                                                 wmask = MASK_PATTERN;
      default:                                                     wmask = MASK_NONE;
    endcase
  endfunction

  assign hit = (csr_addr < 8'(REG_SPACE));
  assign idx = csr_addr[5:0];
  assign cm_trim = reg_q[REG_CM_TRIM[5:0]];

  // register writes; reserved bits are never stored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < REG_SPACE; i++) reg_q[i] <= REG_RESET;
      reg_q[REG_LINK_CFG[5:0]] <= LINK_CFG_RESET;
    end
    else if (ce && csr_wr && hit)
    begin
      reg_q[idx] <= csr_wdata & wmask(csr_addr);
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csr_rdata <= '0;
    end
    else if (ce && csr_rd)
    begin
      if (csr_addr == REG_STATUS)
        csr_rdata <= {6'h00, (cfg_now.sync_dly < MIN_SYNC_DELAY), stat_s2_q};
      else if (hit)
        csr_rdata <= reg_q[idx] & wmask(csr_addr);
      else
        csr_rdata <= '0;
    end
  end

  // low and high parts joined into whole fields
  always_comb
  begin
    cfg_now.line_len = {reg_q[REG_LINE_LEN_HI[5:0]][3:0], reg_q[REG_LINE_LEN_LO[5:0]]};
    cfg_now.vsize    = {reg_q[REG_VSIZE_HI[5:0]][3:0], reg_q[REG_VSIZE_LO[5:0]]};
    cfg_now.sync_dly = {reg_q[REG_SDLY_HI[5:0]][3:0], reg_q[REG_SDLY_LO[5:0]]};
    cfg_now.hsw      = {reg_q[REG_HSW_HI[5:0]][1:0], reg_q[REG_HSW_LO[5:0]]};
    cfg_now.vsw      = {reg_q[REG_VSW_HI[5:0]][1:0], reg_q[REG_VSW_LO[5:0]]};
    cfg_now.hbp      = reg_q[REG_HBP[5:0]];
    cfg_now.vbp      = reg_q[REG_VBP[5:0]];
    cfg_now.hfp      = reg_q[REG_HFP[5:0]];
    cfg_now.vfp      = reg_q[REG_VFP[5:0]];
    cfg_now.tp_en    = reg_q[REG_PATTERN[5:0]][PATTERN_EN_BIT];
    cfg_now.single   = reg_q[REG_LINK_CFG[5:0]][LINK_SINGLE_BIT];
    cfg_now.hs_low   = reg_q[REG_LINK_CFG[5:0]][HS_LOW_BIT];
    cfg_now.vs_low   = reg_q[REG_LINK_CFG[5:0]][VS_LOW_BIT];
  end

  // hand-off sender: snapshot stays still until the pixel side acks
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_q   <= 1'b0;
      dirty_q <= 1'b1;
      snap_q  <= '0;
    end
    else if (ce)
    begin
      if (dirty_q && (req_q == ack_s2_q))
      begin
        snap_q  <= cfg_now;
        req_q   <= ~req_q;
        dirty_q <= 1'b0;
      end
      // a write in the send cycle is not lost: set wins
      if (csr_wr && hit) dirty_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel domain: reset, enable and request synchronisers
  logic       prst_s1_q, prst_q;        // reset into pixel domain
  logic       pce_s1_q, pce_q;          // enable into pixel domain
  logic       req_s1_q, req_s2_q;       // request synchroniser
  logic       ack_q;                    // ack toggle
  logic       stage_new_q;              // staged config waiting
  cfg_t       stage_q;                  // staged config
  cfg_t       act_q;                    // config in use
  hstate_t    h_state_q;                // line state
  vstate_t    v_state_q;                // pattern frame state
  logic [11:0] h_cnt_q;                 // pixel count within state
  logic [11:0] v_cnt_q;                 // line count within state
  logic [11:0] h_lim;                   // length of current h state
  logic [11:0] v_lim;                   // length of current v state
  logic [12:0] dly_cnt_q;               // sync re-time countdown
  logic       vs_pend_q;                // delayed event carries vsync
  logic [9:0] vs_lines_q;               // normal-mode vsync lines left
  logic       evt_ok;                   // sync event accepted
  logic       launch;                   // delayed sync leaves now
  logic       h_done;                   // h state ends this cycle
  logic       line_end;                 // pattern line ends
  logic       frame_end;                // pattern frame ends
  logic       cfg_bnd;                  // safe point to switch config
  logic       fifo_valid;               // buffered pixel present
  logic       fifo_pop;                 // take buffered pixel
  pixel_t     fifo_pixel;               // buffered pixel
  pixel_t     bar_pixel;                // pattern colour bars
  logic [2:0] bar;                      // bar index
  logic       run_q;                    // pattern running, a flop so no glitch crosses

  // level synchronisers; first stage feeds only the second
  always_ff @(posedge pix_clk)
  begin
    prst_s1_q <= rst;
    prst_q    <= prst_s1_q;
    pce_s1_q  <= ce;
    pce_q     <= pce_s1_q;
    req_s1_q  <= req_q;
    req_s2_q  <= req_s1_q;
  end

  // back to control domain
  always_ff @(posedge clk)
  begin
    ack_s1_q  <= ack_q;
    ack_s2_q  <= ack_s1_q;
    stat_s1_q <= run_q;
    stat_s2_q <= stat_s1_q;
  end

  // the partial line buffer decouples bursty input from the paced output
  pix_fifo #(.W($bits(pixel_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk       (pix_clk),
    .rst       (prst_q),
    .ce        (pce_q),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_pixel),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_pixel)
  );

  // zero-length fields still last one clock so the state machines never stall
  always_comb
  begin
    case (h_state_q)
      H_SYNC:  h_lim = 12'(act_q.hsw);
      H_BP:    h_lim = 12'(act_q.hbp);
      H_ACT:   h_lim = act_q.line_len;
      H_FP:    h_lim = 12'(act_q.hfp);
      default: h_lim = 12'h001;
    endcase
    if (h_lim == '0) h_lim = 12'h001;
    case (v_state_q)
      V_SYNC:  v_lim = 12'(act_q.vsw);
      V_BP:    v_lim = 12'(act_q.vbp);
      V_ACT:   v_lim = act_q.vsize;
      V_FP:    v_lim = 12'(act_q.vfp);
      default: v_lim = 12'h001;
    endcase
    if (v_lim == '0) v_lim = 12'h001;
  end

  assign h_done    = (h_cnt_q + 12'h001 == h_lim);
  assign line_end  = (h_state_q == H_FP) && h_done;
  assign frame_end = line_end && (v_state_q == V_FP) && (v_cnt_q + 12'h001 == v_lim);
  assign evt_ok    = !act_q.tp_en && (in_hs_evt || in_vs_evt);
  assign launch    = !act_q.tp_en && (dly_cnt_q == 13'h0001);
  assign cfg_bnd   = stage_new_q && (((h_state_q == H_IDLE) && (dly_cnt_q == '0)
                     && !evt_ok) || frame_end);
  assign fifo_pop  = (h_state_q == H_ACT) && !act_q.tp_en;
  assign bar       = h_cnt_q[BAR_LSB +: 3];
  assign bar_pixel = {{COMP_W{bar[2]}}, {COMP_W{bar[1]}}, {COMP_W{bar[0]}}};

  // config receiver, then switch-over only at a line or frame edge
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      ack_q       <= 1'b0;
      stage_new_q <= 1'b0;
      stage_q     <= '0;
      act_q       <= CFG_RESET;
    end
    else if (pce_q)
    begin
      if (cfg_bnd)
      begin
        act_q       <= stage_q;
        stage_new_q <= 1'b0;
      end
      if (req_s2_q != ack_q)
      begin
        stage_q     <= snap_q;
        ack_q       <= req_s2_q;
        stage_new_q <= 1'b1;
      end
    end
  end

  // sync re-time delay; a new event restarts it, only one is in flight
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      dly_cnt_q <= '0;
      vs_pend_q <= 1'b0;
    end
    else if (pce_q)
    begin
      if (evt_ok)
      begin
        dly_cnt_q <= 13'(act_q.sync_dly) + DLY_LATENCY;
        vs_pend_q <= in_vs_evt;
      end
      else if (dly_cnt_q != '0)
      begin
        dly_cnt_q <= dly_cnt_q - 13'h0001;
      end
    end
  end

  // line state machine on the pixel clock
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      h_state_q <= H_IDLE;
      h_cnt_q   <= '0;
    end
    else if (pce_q)
    begin
      h_cnt_q <= h_done ? '0 : h_cnt_q + 12'h001;
      if (launch)
      begin
        h_state_q <= H_SYNC;
        h_cnt_q   <= '0;
      end
      else
      begin
        case (h_state_q)
          H_IDLE:
          begin
            h_cnt_q <= '0;
            if (act_q.tp_en) h_state_q <= H_SYNC;
          end
          H_SYNC:  if (h_done) h_state_q <= H_BP;
          H_BP:    if (h_done) h_state_q <= H_ACT;
          H_ACT:
          begin
            if (h_done) h_state_q <= act_q.tp_en ? H_FP : H_IDLE;
          end
          H_FP:
          begin
            if (h_done) h_state_q <= act_q.tp_en ? H_SYNC : H_IDLE;
          end
          default: h_state_q <= H_IDLE;
        endcase
      end
    end
  end

  // pattern frame state machine, one step per completed line
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      v_state_q <= V_SYNC;
      v_cnt_q   <= '0;
    end
    else if (pce_q)
    begin
      if (!act_q.tp_en)
      begin
        v_state_q <= V_SYNC;
        v_cnt_q   <= '0;
      end
      else if (line_end)
      begin
        if (v_cnt_q + 12'h001 == v_lim)
        begin
          v_cnt_q <= '0;
          case (v_state_q)
            V_SYNC:  v_state_q <= V_BP;
            V_BP:    v_state_q <= V_ACT;
            V_ACT:   v_state_q <= V_FP;
            V_FP:    v_state_q <= V_SYNC;
            default: v_state_q <= V_SYNC;
          endcase
        end
        else
        begin
          v_cnt_q <= v_cnt_q + 12'h001;
        end
      end
    end
  end

  // normal-mode vsync counted in lines from the delayed vsync event
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      vs_lines_q <= '0;
    end
    else if (pce_q)
    begin
      if (launch && vs_pend_q)
        vs_lines_q <= act_q.vsw;
      else if (launch && (vs_lines_q != '0))
        vs_lines_q <= vs_lines_q - 10'h001;
    end
  end

  // registered output with polarity; underrun shows black pixels
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)
    begin
      vid_out   <= '{de: 1'b0, hs: 1'b1, vs: 1'b1, rgb: '0};
      chan_a_en <= 1'b1;
      chan_b_en <= 1'b0;
      run_q     <= 1'b0;
    end
    else if (pce_q)
    begin
      vid_out.hs <= (h_state_q == H_SYNC) ^ act_q.hs_low;
      vid_out.vs <= (act_q.tp_en ? (v_state_q == V_SYNC)
                                 : (vs_lines_q != '0)) ^ act_q.vs_low;
      vid_out.de <= (h_state_q == H_ACT) && (!act_q.tp_en || v_state_q == V_ACT);
      if (act_q.tp_en)
        vid_out.rgb <= bar_pixel;
      else
        vid_out.rgb <= fifo_valid ? fifo_pixel : '0;
      chan_a_en <= 1'b1;
      chan_b_en <= !act_q.single;
      run_q     <= act_q.tp_en && (h_state_q != H_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks, pixel domain
  default clocking cb @(posedge pix_clk); endclocking
  default disable iff (prst_q || !pce_q);
  logic [11:0] de_run_q;                // length of current de run
  always_ff @(posedge pix_clk)
  begin
    if (prst_q)  de_run_q <= '0;
    else if (pce_q) de_run_q <= vid_out.de ? de_run_q + 12'h001 : '0;
  end
  sequence s_evt;
    evt_ok;
  endsequence
  sequence s_countdown_end;
    (dly_cnt_q == 13'h0002) && !evt_ok && !act_q.tp_en;
  endsequence

  AST_DLY_LOAD: assert property (s_evt |=> dly_cnt_q ==
    13'($past(act_q.sync_dly)) + DLY_LATENCY) else $error("bad sync delay load");
  AST_DLY_RUN: assert property (s_countdown_end |=> launch ##1
    (h_state_q == H_SYNC) && (h_cnt_q == '0)) else $error("delayed sync late");
  AST_HSW: assert property ((h_state_q == H_BP) && ($past(h_state_q) == H_SYNC)
    |-> $past(h_cnt_q) + 12'h001 == $past(h_lim)) else $error("hsync width wrong");
  AST_HBP: assert property (((h_state_q == H_BP) && h_done && !launch)
    |=> h_state_q == H_ACT) else $error("back porch not followed by active");
  AST_LINE_LEN: assert property ($fell(vid_out.de) && !act_q.tp_en && !$past(launch, 2)
    |-> de_run_q == $past(h_lim, 2)) else $error("active run length wrong");
  AST_HFP_TP: assert property ((h_state_q == H_FP) |-> act_q.tp_en)
    else $error("front porch outside pattern mode");
  AST_V_STEP: assert property ($changed(v_state_q) && act_q.tp_en
    |-> $past(line_end)) else $error("frame state moved mid-line");
  AST_VBP: assert property ((v_state_q == V_BP) && line_end && (v_cnt_q + 12'h001 == v_lim)
    |=> (v_state_q == V_ACT) && (v_cnt_q == '0)) else $error("vertical back porch wrong");
  AST_POL: assert property ((h_state_q == H_SYNC) |=> vid_out.hs == !$past(act_q.hs_low))
    else $error("hsync polarity wrong");
  AST_CHAN: assert property (chan_b_en |-> chan_a_en && !$past(act_q.single))
    else $error("channel B on in single link");
  AST_CFG: assert property ($changed(act_q) |-> $past(cfg_bnd))
    else $error("config switched off boundary");
  AST_TP_START: assert property ((h_state_q == H_IDLE) && act_q.tp_en && !launch
    |=> h_state_q == H_SYNC) else $error("pattern did not start");
endmodule

// file: test/panel_model.sv
`timescale 1ns/1ns
////////////////////////////////////////
// panel side: it only listens to the link
module panel_model
  import vtg_pkg::*;
(
  input wire logic pix_clk, // pixel clock
  input wire vid_t vid,     // re-timed video
  input wire logic hs_act   // hs level in sync
);
  int     cyc  = 0; // edges seen
  int     hs_t = 0; // edge where hs began
  int     hs_w = 0; // width of last hs
  int     de_t = 0; // edge of first pixel
  logic   hs_p = 0; // hs active last edge
  pixel_t got[$];   // pixels latched
  // samples the old value at each edge, as a real receiver would
  always @(posedge pix_clk)
  begin
    if (vid.hs === hs_act)
      hs_w = hs_p ? hs_w + 1 : 1;
    if (vid.hs === hs_act && !hs_p)
      hs_t = cyc;
    if (vid.de === 1'b1 && got.size() == 0)
      de_t = cyc;
    if (vid.de === 1'b1)
      got.push_back(vid.rgb);
    hs_p = (vid.hs === hs_act);
    cyc = cyc + 1;
  end
endmodule

// file: test/lvds_video_timing_generator_tb.sv
`timescale 1ns/1ns
module lvds_video_timing_generator_tb
  import vtg_pkg::*;
;
  logic       clk, rst, ce, pix_clk, ok;        // clocks and control
  logic       csr_wr, csr_rd, in_valid, hs_act; // strobes
  logic       in_hs_evt, in_vs_evt;             // sync events
  logic [7:0] csr_addr, csr_wdata, rdv;         // register bus
  logic [7:0] csr_rdata, cm_trim;               // outputs
  logic       in_ready, chan_a_en, chan_b_en;   // outputs
  pixel_t     in_pixel;                         // offered pixel
  vid_t       vid_out;                          // video out
  int         fail_count, samples_checked, d, ev;
  pixel_t     q[$];                             // pixels accepted
  logic [7:0] ex[16];                           // written values
  logic [7:0] ra[16] = '{8'h1b, 8'h20, 8'h21, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2c,
                         8'h2d, 8'h30, 8'h31, 8'h34, 8'h36, 8'h38, 8'h3a, 8'h3c};
  logic [7:0] rm[16] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff,
                         8'h03, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'h10};
  // pattern frame: vsize 2, vertical porches 1, front porch 4, then enable
  logic [7:0] pa[6] = '{8'h24, 8'h25, 8'h36, 8'h38, 8'h3a, 8'h3c};
  logic [7:0] pv[6] = '{8'h02, 8'h00, 8'h01, 8'h04, 8'h01, 8'h10};
  lvds_video_timing_generator i_dut (.*);
  panel_model i_panel (.pix_clk(pix_clk), .vid(vid_out), .hs_act(hs_act));
  ////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // link clock, phase unrelated to clk
  initial
  begin
    pix_clk = 0;
    #7;
    forever #16 pix_clk = ~pix_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // an idle edge first, so a strobe never drops and rises in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 {csr_addr, csr_wdata, csr_wr} = {a, v, 1'b1};
    @(posedge clk);
    #1 csr_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 {csr_addr, csr_rd} = {a, 1'b1};
    @(posedge clk);
    #1 csr_rd = 0;
    @(posedge clk);
    #1 rdv = csr_rdata;
  endtask
  // one sync event pulse, then wait out the delay and a whole line
  task automatic evt(input logic v);
    repeat (20) @(posedge pix_clk);
    #1 ev = i_panel.cyc;
    {in_hs_evt, in_vs_evt} = {!v, v};
    @(posedge pix_clk);
    #1 {in_hs_evt, in_vs_evt} = 2'b00;
    repeat (d + 40) @(posedge pix_clk);
    #1;
  endtask
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #300000;
    fail_count++;
    test_done;
  end
  ////////////////////////////////////////
  initial
  begin
    {csr_wr, csr_rd, in_valid, in_hs_evt, in_vs_evt, hs_act, ok} = '0;
    {csr_addr, csr_wdata, in_pixel, rst, ce} = {40'h0, 2'b11};
    {fail_count, samples_checked} = '0;
    void'($urandom(32'hc45a));
    // pixel side needs three of its own edges in reset
    repeat (5) @(posedge pix_clk);
    #1 rst = 0;
    chk("chan_a_en", 1, chan_a_en);
    chk("chan_b_en", 0, chan_b_en);
    rd(8'h18);
    chk("link_cfg", 8'h70, rdv);
    for (int i = 0; i < 16; i++)
    begin
      rd(ra[i]);
      chk("reset", 0, rdv);
      ex[i] = 8'($urandom) & (i == 15 ? 8'hef : 8'hff);
      wr(ra[i], ex[i]);
    end
    for (int i = 0; i < 16; i++)
    begin
      rd(ra[i]);
      chk("readback", ex[i] & rm[i], rdv);
    end
    chk("cm_trim", ex[0], cm_trim);
    wr(8'h40, 8'hff);
    rd(8'h40);
    chk("unmapped", 0, rdv);
    d = 32 + $urandom % 8;
    wr(8'h18, 8'h00);
    wr(8'h20, 8'h10);
    wr(8'h21, 8'h00);
    wr(8'h28, d[7:0]);
    wr(8'h29, 8'h00);
    wr(8'h2c, 8'h03);
    wr(8'h2d, 8'h00);
    wr(8'h34, 8'h02);
    repeat (20) @(posedge pix_clk);
    #1 hs_act = 1;
    chk("chan_b_en", 1, chan_b_en);
    chk("hs_idle", 0, vid_out.hs);
    // fill the buffer until it refuses; data holds while refused
    {in_pixel, in_valid} = {24'($urandom), 1'b1};
    repeat (20)
    begin
      ok = in_ready;
      @(posedge pix_clk);
      #1 if (ok) q.push_back(in_pixel);
      if (ok) in_pixel = 24'($urandom);
    end
    in_valid = 0;
    chk("fill", 16, q.size());
    evt(1'b0);
    // delay, ten pipeline clocks, the sync state flop and the output flop
    chk("hs_delay", d + 12, i_panel.hs_t - ev);
    chk("hs_width", 3, i_panel.hs_w);
    chk("back_porch", 5, i_panel.de_t - i_panel.hs_t);
    chk("line_len", 16, i_panel.got.size());
    foreach (q[i]) chk("pixel", q[i], i_panel.got[i]);
    // vsync of two lines, counted on the delayed syncs that follow it
    wr(8'h30, 8'h02);
    wr(8'h31, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      evt(i == 0);
      chk("vsync", i < 2, vid_out.vs);
    end
    foreach (pa[i]) wr(pa[i], pv[i]);
    repeat (200) @(posedge pix_clk);
    #1 ev = i_panel.got.size();
    // two frames of six lines, each line 3 + 2 + 16 + 4 clocks
    repeat (300) @(posedge pix_clk);
    #1 chk("tp_pixels", 64, i_panel.got.size() - ev);
    chk("tp_hs_width", 3, i_panel.hs_w);
    rd(8'h3e);
    chk("status", 8'h01, rdv);
    test_done;
  end
endmodule
